// >>> hw/regref_consts.svh
// Constants for the register-reference microoperation unit.
// Assumes a 16-bit word and a two-bit register port address.
`ifndef REGREF_CONSTS_SVH
`define REGREF_CONSTS_SVH

// -------------------------------------------------------------
// Register port offsets
// -------------------------------------------------------------
`define OFS_ACC_A 2'h0
`define OFS_ACC_B 2'h1
`define OFS_EXT 2'h2
`define OFS_OVF 2'h3

// -------------------------------------------------------------
// Field values and reset values
// -------------------------------------------------------------
`define GRP_REGREF 4'h0
`define ALT_CLEAR 2'h1
`define ALT_INVERT 2'h2
`define ALT_ONES 2'h3
`define RST_ACC 16'h0000
`define RST_BIT 1'h0
`define ACC_MAX_POS 16'h7fff
`define PC_STEP_ONE 2'h1
`define PC_STEP_TWO 2'h2

`endif

// >>> hw/regref_pkg.sv
// Types for the register-reference microoperation unit.
// Assumes the sequencer hands over one 16-bit word per strobe.
package regref_pkg;

	// ---------------------------------------------------------
	// Shift and rotate codes
	// ---------------------------------------------------------
	typedef enum logic [2:0] {
		SH_ARITH_L = 3'h0,
		SH_ARITH_R = 3'h1,
		SH_ROT_L = 3'h2,
		SH_ROT_R = 3'h3,
		SH_LOGIC_L = 3'h4,
		SH_EXT_R = 3'h5,
		SH_EXT_L = 3'h6,
		SH_ROT_L4 = 3'h7
	} sh_op_t;

	// ---------------------------------------------------------
	// Word layouts
	// ---------------------------------------------------------
	typedef struct packed {
		logic [3:0] grp;
		logic sel_b;
		logic alt_grp;
		logic en1;
		sh_op_t op1;
		logic clr_e;
		logic en2;
		logic tst_lsb;
		sh_op_t op2;
	} sr_word_t;

	typedef struct packed {
		logic [3:0] grp;
		logic sel_b;
		logic alt_grp;
		logic [1:0] acc_alt;
		logic [1:0] ext_alt;
		logic tst_ext;
		logic tst_sign;
		logic tst_lsb;
		logic inc;
		logic tst_zero;
		logic rev;
	} as_word_t;

endpackage : regref_pkg

// >>> hw/register_ref_microops.sv
// Register-reference microoperation unit: shift-rotate and
// alter-skip groups on accumulators A, B and the extend bit.
// Assumes the sequencer strobes one word per cycle on mclk and
// software uses the register port between instructions.
//
// Overview of operation
// - arithmetic right shift keeps sign, copies it into bit 14
// - plain right rotate moves bit 0 into bit 15
// - right rotate through extend: bit 0 to E, E to bit 15
// - left rotate through extend: bit 15 to E, E to bit 0
// - logical left shift is arithmetic left shift, sign cleared
// - four-place left rotate moves bits 15..12 to 3..0
// - bit 11 picks A or B; bits 9:8 clear, invert, fill ones
// - accumulator complement inverts every bit
// - bits 7:6 clear, invert or set the extend bit
// - extend complement inverts the extend bit
// - bit 10 set selects the alter-skip group
// - combined microoperations act left to right, except that with reverse sense all tests follow increment
// - several skip tests skip when any one holds, except reverse-sense sign plus parity, which skips only when both hold
// - extend test skips when extend is zero
// - sign test, bit 4, skips when bit 15 is zero
// - parity test, bit 3, skips when bit 0 is zero
// - increment adds one, may set extend or overflow
// - zero test, bit 1, skips when all 16 bits are zero
// - a taken skip advances the program counter by two
// - reverse sense tests non-zero; alone skips always
// - bits 9 and 4 enable shifts; disabled E-rotate updates E
`timescale 1ns/100ps
`include "regref_consts.svh"

module register_ref_microops
	import regref_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Sequencer side
	input wire logic exec_stb,
	input wire logic [15:0] exec_word,
	output logic exec_done,
	output logic skip_taken,
	output logic [1:0] pc_step,
	// Register port
	input wire logic [1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Machine state
	output logic [15:0] acc_a,
	output logic [15:0] acc_b,
	output logic ext_bit,
	output logic ovf_bit
);

	// ---------------------------------------------------------
	// One shift or rotate step on {E, acc}
	// ---------------------------------------------------------
	function automatic logic [16:0] shift_step(
		input sh_op_t op,
		input logic en,
		input logic [16:0] ea
	);
		logic [15:0] v;
		logic e;
		logic [15:0] r;
		logic re;
		v = ea[15:0];
		e = ea[16];
		r = v;
		re = e;
		case (op)
			SH_ARITH_L: r = {v[15], v[13:0], 1'b0};
			SH_ARITH_R: r = {v[15], v[15:1]};
			SH_ROT_L: r = {v[14:0], v[15]};
			SH_ROT_R: r = {v[0], v[15:1]};
			SH_LOGIC_L: r = {1'b0, v[13:0], 1'b0};
			SH_EXT_R: begin
				r = {e, v[15:1]};
				re = v[0];
			end
			SH_EXT_L: begin
				r = {v[14:0], e};
				re = v[15];
			end
			default: r = {v[11:0], v[15:12]};
		endcase
		if (!en) begin
			// Disabled E-rotate still moves E
			r = v;
		end
		return {re, r};
	endfunction : shift_step

	// ---------------------------------------------------------
	// State
	// ---------------------------------------------------------
	logic [15:0] a_reg, a_next;
	logic [15:0] b_reg, b_next;
	logic e_reg, e_next;
	logic o_reg, o_next;
	logic done_reg, done_next;
	logic skip_reg, skip_next;
	logic [1:0] step_reg, step_next;
	logic [15:0] rd_reg, rd_next;

	// Execution results
	logic [15:0] x_acc;
	logic x_e;
	logic x_o;
	logic x_skip;
	logic x_valid;

	sr_word_t sw;
	as_word_t aw;
	assign sw = exec_word;
	assign aw = exec_word;

	// ---------------------------------------------------------
	// Microoperation datapath
	// ---------------------------------------------------------
	logic [15:0] acc0;
	logic [16:0] ea1;
	logic [16:0] ea2;
	logic [16:0] inc_sum;
	logic c_ext, c_sign, c_lsb, c_zero;
	logic any_test;

	always_comb begin
		x_valid = exec_stb && (aw.grp == `GRP_REGREF);
		acc0 = aw.sel_b ? b_reg : a_reg;
		x_acc = acc0;
		x_e = e_reg;
		x_o = o_reg;
		x_skip = 1'b0;
		ea1 = {e_reg, acc0};
		ea2 = ea1;
		inc_sum = 17'h00000;
		c_ext = 1'b0;
		c_sign = 1'b0;
		c_lsb = 1'b0;
		c_zero = 1'b0;
		any_test = 1'b0;
		if (aw.alt_grp) begin
			// Fields applied in order on prior result; reverse-sense tests follow increment
			case (aw.acc_alt)
				`ALT_CLEAR: x_acc = `RST_ACC;
				`ALT_INVERT: x_acc = ~x_acc;
				`ALT_ONES: x_acc = ~`RST_ACC;
				default: x_acc = x_acc;
			endcase
			case (aw.ext_alt)
				`ALT_CLEAR: x_e = 1'b0;
				`ALT_INVERT: x_e = ~x_e;
				`ALT_ONES: x_e = 1'b1;
				default: x_e = x_e;
			endcase
			c_ext = aw.tst_ext && !x_e;
			c_sign = aw.tst_sign && !x_acc[15];
			c_lsb = aw.tst_lsb && !x_acc[0];
			if (aw.inc) begin
				inc_sum = {1'b0, x_acc} + 17'h00001;
				if (inc_sum[16]) begin
					x_e = 1'b1;
				end
				if (x_acc == `ACC_MAX_POS) begin
					x_o = 1'b1;
				end
				x_acc = inc_sum[15:0];
			end
			c_zero = aw.tst_zero && (x_acc == 16'h0000);
			any_test = aw.tst_ext || aw.tst_sign ||
				aw.tst_lsb || aw.tst_zero;
			if (!aw.rev) begin
				x_skip = c_ext || c_sign || c_lsb || c_zero;
			end else if (!any_test) begin
				x_skip = 1'b1;
			end else if (aw.tst_sign && aw.tst_lsb) begin
				x_skip = (x_acc[15] && x_acc[0]) ||
					(aw.tst_ext && x_e) ||
					(aw.tst_zero && x_acc != 16'h0000);
			end else begin
				x_skip = (aw.tst_ext && x_e) ||
					(aw.tst_sign && x_acc[15]) ||
					(aw.tst_lsb && x_acc[0]) ||
					(aw.tst_zero && x_acc != 16'h0000);
			end
		end else begin
			ea1 = shift_step(sw.op1, sw.en1, {e_reg, acc0});
			ea2 = ea1;
			if (sw.clr_e) begin
				ea2[16] = 1'b0;
			end
			x_skip = sw.tst_lsb && !ea2[0];
			ea2 = shift_step(sw.op2, sw.en2, ea2);
			x_acc = ea2[15:0];
			x_e = ea2[16];
		end
	end

	// ---------------------------------------------------------
	// Next-state: execution wins over a register port write
	// ---------------------------------------------------------
	always_comb begin
		a_next = a_reg;
		b_next = b_reg;
		e_next = e_reg;
		o_next = o_reg;
		done_next = exec_stb;
		skip_next = 1'b0;
		step_next = step_reg;
		rd_next = 16'h0000;
		if (x_valid) begin
			// Results and skip land on the same edge
			if (aw.sel_b) begin
				b_next = x_acc;
			end else begin
				a_next = x_acc;
			end
			e_next = x_e;
			o_next = x_o;
			skip_next = x_skip;
			step_next = x_skip ? `PC_STEP_TWO : `PC_STEP_ONE;
		end else if (exec_stb) begin
			step_next = `PC_STEP_ONE;
		end else if (reg_wr) begin
			if (reg_addr == `OFS_ACC_A) begin
				a_next = reg_wdata;
			end else if (reg_addr == `OFS_ACC_B) begin
				b_next = reg_wdata;
			end else if (reg_addr == `OFS_EXT) begin
				e_next = reg_wdata[0];
			end else begin
				o_next = reg_wdata[0];
			end
		end
		if (reg_rd) begin
			if (reg_addr == `OFS_ACC_A) begin
				rd_next = a_reg;
			end else if (reg_addr == `OFS_ACC_B) begin
				rd_next = b_reg;
			end else if (reg_addr == `OFS_EXT) begin
				rd_next = {15'h0000, e_reg};
			end else begin
				rd_next = {15'h0000, o_reg};
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			a_reg <= `RST_ACC;
			b_reg <= `RST_ACC;
			e_reg <= `RST_BIT;
			o_reg <= `RST_BIT;
			done_reg <= 1'b0;
			skip_reg <= 1'b0;
			step_reg <= `PC_STEP_ONE;
			rd_reg <= 16'h0000;
		end else begin
			a_reg <= a_next;
			b_reg <= b_next;
			e_reg <= e_next;
			o_reg <= o_next;
			done_reg <= done_next;
			skip_reg <= skip_next;
			step_reg <= step_next;
			rd_reg <= rd_next;
		end
	end

	assign acc_a = a_reg;
	assign acc_b = b_reg;
	assign ext_bit = e_reg;
	assign ovf_bit = o_reg;
	assign exec_done = done_reg;
	assign skip_taken = skip_reg;
	assign pc_step = step_reg;
	assign reg_rdata = rd_reg;

	// ---------------------------------------------------------
	// Checks
	// ---------------------------------------------------------
	logic sr_one_a;
	logic as_a;
	assign sr_one_a = exec_stb && exec_word[15:9] == 7'h01 &&
		exec_word[5:0] == 6'h00;
	assign as_a = exec_stb && exec_word[15:10] == 6'h01;

	arith_right_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sr_one_a && sw.op1 == SH_ARITH_R |=>
		acc_a == {$past(acc_a[15]), $past(acc_a[15:1])})
		else $error("arithmetic right shift wrong");

	rotate_right_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sr_one_a && sw.op1 == SH_ROT_R |=>
		acc_a == {$past(acc_a[0]), $past(acc_a[15:1])})
		else $error("right rotate wrong");

	ring_right_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sr_one_a && sw.op1 == SH_EXT_R |=>
		{acc_a, ext_bit} == $past({ext_bit, acc_a}))
		else $error("right rotate through extend wrong");

	ring_left_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sr_one_a && sw.op1 == SH_EXT_L |=>
		{ext_bit, acc_a} == $past({acc_a, ext_bit}))
		else $error("left rotate through extend wrong");

	drop_sign_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sr_one_a && sw.op1 == SH_LOGIC_L |=>
		acc_a == {2'h0, $past(acc_a[13:0])} << 1)
		else $error("logical left shift wrong");

	rotate_four_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sr_one_a && sw.op1 == SH_ROT_L4 |=>
		acc_a == {$past(acc_a[11:0]), $past(acc_a[15:12])})
		else $error("four-place rotate wrong");

	ones_fill_a: assert property (@(posedge mclk) disable iff (!rst_b)
		as_a && aw.acc_alt == `ALT_ONES && !aw.inc |=>
		acc_a == 16'hffff && acc_b == $past(acc_b))
		else $error("ones fill wrong");

	invert_acc_a: assert property (@(posedge mclk) disable iff (!rst_b)
		as_a && aw.acc_alt == `ALT_INVERT && !aw.inc |=>
		acc_a == ~$past(acc_a))
		else $error("complement wrong");

	ext_alter_a: assert property (@(posedge mclk) disable iff (!rst_b)
		as_a && aw.ext_alt != 2'h0 && !aw.inc |=>
		ext_bit == ($past(aw.ext_alt) == `ALT_INVERT ?
		!$past(ext_bit) : $past(aw.ext_alt) == `ALT_ONES))
		else $error("extend alteration wrong");

	disabled_rot_a: assert property (@(posedge mclk) disable iff (!rst_b)
		exec_stb && exec_word[15:9] == 7'h00 &&
		sw.op1 == SH_EXT_L && exec_word[5:0] == 6'h00 |=>
		acc_a == $past(acc_a) && ext_bit == $past(acc_a[15]))
		else $error("disabled rotate missed extend");

	sign_skip_a: assert property (@(posedge mclk) disable iff (!rst_b)
		as_a && exec_word[9:0] == 10'h010 |=>
		skip_taken == !$past(acc_a[15]))
		else $error("sign skip wrong");

	lsb_skip_a: assert property (@(posedge mclk) disable iff (!rst_b)
		as_a && exec_word[9:0] == 10'h008 |=>
		skip_taken == !$past(acc_a[0]))
		else $error("parity skip wrong");

	ext_skip_a: assert property (@(posedge mclk) disable iff (!rst_b)
		as_a && exec_word[9:0] == 10'h020 |=>
		skip_taken == !$past(ext_bit))
		else $error("extend skip wrong");

	zero_skip_a: assert property (@(posedge mclk) disable iff (!rst_b)
		as_a && exec_word[9:0] == 10'h002 |=>
		skip_taken == ($past(acc_a) == 16'h0000))
		else $error("zero skip wrong");

	any_skip_a: assert property (@(posedge mclk) disable iff (!rst_b)
		as_a && exec_word[9:0] == 10'h018 |=>
		skip_taken == !($past(acc_a[15]) && $past(acc_a[0])))
		else $error("combined skip wrong");

	rev_skip_a: assert property (@(posedge mclk) disable iff (!rst_b)
		as_a && exec_word[9:0] == 10'h019 |=>
		skip_taken == ($past(acc_a[15]) && $past(acc_a[0])))
		else $error("reversed combined skip wrong");

	rev_alone_a: assert property (@(posedge mclk) disable iff (!rst_b)
		as_a && exec_word[9:0] == 10'h001 |=>
		skip_taken && pc_step == `PC_STEP_TWO)
		else $error("lone reverse sense did not skip");

	inc_flags_a: assert property (@(posedge mclk) disable iff (!rst_b)
		as_a && exec_word[9:0] == 10'h004 &&
		acc_a == 16'h7fff |=>
		acc_a == 16'h8000 && ovf_bit)
		else $error("increment overflow wrong");

	inc_carry_a: assert property (@(posedge mclk) disable iff (!rst_b)
		as_a && exec_word[9:0] == 10'h004 &&
		acc_a == 16'hffff |=>
		acc_a == 16'h0000 && ext_bit)
		else $error("increment carry wrong");

	pc_step_a: assert property (@(posedge mclk) disable iff (!rst_b)
		exec_done |->
		pc_step == (skip_taken ? `PC_STEP_TWO : `PC_STEP_ONE))
		else $error("step disagrees with skip");

	alter_order_a: assert property (@(posedge mclk) disable iff (!rst_b)
		as_a && exec_word[9:0] == 10'h106 |=>
		acc_a == 16'h0001 && !skip_taken)
		else $error("left to right order wrong");

endmodule : register_ref_microops

// >>> tb/seq_model.sv
// Sequencer model: hands the unit one word per call, advances a PC.
// Assumes the unit answers exec_stb with exec_done a cycle later.
`timescale 1ns/100ps

module seq_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Unit side
	output logic exec_stb,
	output logic [15:0] exec_word,
	input wire logic exec_done,
	input wire logic skip_taken,
	input wire logic [1:0] pc_step
);
	logic [15:0] pc;

	initial begin
		exec_stb = 1'b0;
		exec_word = 16'h0000;
		pc = 16'h0000;
	end

	// Words given never mix A and B
	task automatic issue(input logic [15:0] w, output int lat,
		output logic sk);
		@(posedge mclk);
		exec_stb <= 1'b1;
		exec_word <= w;
		@(posedge mclk);
		exec_stb <= 1'b0;
		exec_word <= ~w;
		#1;
		lat = 1;
		while (exec_done !== 1'b1 && lat < 8) begin
			@(posedge mclk);
			#1;
			lat++;
		end
		sk = skip_taken;
		pc = pc + 16'(pc_step);
	endtask : issue
endmodule : seq_model

// >>> tb/register_ref_microops_test.sv
// Self-checking bench for the register-reference unit.
// Assumes seq_model and the regref package and header are compiled.
`timescale 1ns/100ps
`include "regref_consts.svh"
`define CHK(nm, e, g) begin \
	compares++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("[ERR] %s expected %h seen %h", nm, e, g); \
	end \
end

module register_ref_microops_test;
	logic mclk;
	logic rst_b;
	logic exec_stb;
	logic [15:0] exec_word;
	logic exec_done;
	logic skip_taken;
	logic [1:0] pc_step;
	logic [1:0] reg_addr;
	logic [15:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [15:0] reg_rdata;
	logic [15:0] acc_a;
	logic [15:0] acc_b;
	logic ext_bit;
	logic ovf_bit;
	int n_fail;
	int compares;

	register_ref_microops register_ref_microops_i (.mclk(mclk),
		.rst_b(rst_b), .exec_stb(exec_stb), .exec_word(exec_word),
		.exec_done(exec_done), .skip_taken(skip_taken),
		.pc_step(pc_step), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.acc_a(acc_a), .acc_b(acc_b), .ext_bit(ext_bit),
		.ovf_bit(ovf_bit));

	seq_model seq_model_i (.mclk(mclk), .rst_b(rst_b),
		.exec_stb(exec_stb), .exec_word(exec_word),
		.exec_done(exec_done), .skip_taken(skip_taken),
		.pc_step(pc_step));

	initial mclk = 1'b0;
	always #25 mclk = ~mclk;

	// ---------------------------------------------------------
	// Register port and execution helpers
	// ---------------------------------------------------------
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr

	task automatic rd(input logic [1:0] a, input logic [15:0] e);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		`CHK("read data", e, reg_rdata);
		@(posedge mclk);
		#1;
		`CHK("read idle", 16'h0000, reg_rdata);
	endtask : rd

	task test_done;
		$display("Checks %0d, failures %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	// Flags f are {E in, E out, overflow out, skip}
	task automatic step_op(input logic [15:0] w, input logic [15:0] ai,
		input logic [15:0] ax, input logic [3:0] f);
		logic [1:0] s;
		int lat;
		logic sk;
		logic [15:0] p;
		s = w[11] ? `OFS_ACC_B : `OFS_ACC_A;
		wr(s, ai);
		wr(s ^ 2'h1, 16'h5a5a);
		wr(`OFS_EXT, {15'h0000, f[3]});
		wr(`OFS_OVF, 16'h0000);
		p = seq_model_i.pc + (f[0] ? 16'h0002 : 16'h0001);
		seq_model_i.issue(w, lat, sk);
		`CHK("latency", 1, lat);
		if (lat >= 8)
			test_done();
		else begin
			`CHK("acc", ax, w[11] ? acc_b : acc_a);
			`CHK("other acc", 16'h5a5a, w[11] ? acc_a : acc_b);
			`CHK("ext", f[2], ext_bit);
			`CHK("ovf", f[1], ovf_bit);
			`CHK("skip", f[0], sk);
			`CHK("pc", p, seq_model_i.pc);
			`CHK("pc_step", f[0] ? `PC_STEP_TWO : `PC_STEP_ONE, pc_step);
		end
	endtask : step_op

	// ---------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------
	task automatic t_reset;
		#1;
		`CHK("reset a", `RST_ACC, acc_a);
		`CHK("reset b", `RST_ACC, acc_b);
		`CHK("reset e", `RST_BIT, ext_bit);
		`CHK("reset step", `PC_STEP_ONE, pc_step);
		`CHK("reset done", 1'b0, exec_done);
		rd(`OFS_OVF, 16'h0000);
		rd(`OFS_ACC_B, 16'h0000);
	endtask : t_reset

	task automatic t_regport;
		wr(`OFS_ACC_A, 16'hbeef);
		rd(`OFS_ACC_A, 16'hbeef);
		wr(`OFS_EXT, 16'hffff);
		rd(`OFS_EXT, 16'h0001);
		wr(`OFS_OVF, 16'h0003);
		rd(`OFS_OVF, 16'h0001);
	endtask : t_regport

	task automatic t_shift;
		step_op(16'h0200, 16'hc001, 16'h8002, 4'b0000);
		step_op(16'h0240, 16'h8005, 16'hc002, 4'b0000);
		step_op(16'h0ac0, 16'h0003, 16'h8001, 4'b0000);
		step_op(16'h02c0, 16'h0003, 16'h8001, 4'b0000);
		step_op(16'h0180, 16'h8001, 16'h8001, 4'b0100);
		step_op(16'h0300, 16'hc001, 16'h0002, 4'b0000);
		step_op(16'h0340, 16'h0001, 16'h0000, 4'b0100);
		step_op(16'h0340, 16'h0000, 16'h8000, 4'b1000);
		step_op(16'h0b40, 16'h0002, 16'h8001, 4'b1000);
		step_op(16'h0380, 16'h8000, 16'h0000, 4'b0100);
		step_op(16'h0b80, 16'h4000, 16'h8001, 4'b1000);
		step_op(16'h03c0, 16'h1234, 16'h2341, 4'b0000);
		step_op(16'h0bc0, 16'h8765, 16'h7658, 4'b0000);
		step_op(16'h0140, 16'h0001, 16'h0001, 4'b0100);
		step_op(16'h0006, 16'h8000, 16'h8000, 4'b0100);
		step_op(16'h03d6, 16'h8123, 16'h2471, 4'b1000);
		step_op(16'h0028, 16'h0002, 16'h0002, 4'b1001);
		step_op(16'h0000, 16'h1234, 16'h1234, 4'b1100);
	endtask : t_shift

	task automatic t_alter;
		step_op(16'h0640, 16'h8005, 16'h7ffa, 4'b1000);
		step_op(16'h0428, 16'h0002, 16'h0002, 4'b1101);
		step_op(16'h0500, 16'h1234, 16'h0000, 4'b1100);
		step_op(16'h0600, 16'h1234, 16'hedcb, 4'b0000);
		step_op(16'h0700, 16'h1234, 16'hffff, 4'b0000);
		step_op(16'h0f00, 16'h1234, 16'hffff, 4'b0000);
		step_op(16'h0e00, 16'h00ff, 16'hff00, 4'b0000);
		step_op(16'h0440, 16'h1234, 16'h1234, 4'b1000);
		step_op(16'h0480, 16'h1234, 16'h1234, 4'b0100);
		step_op(16'h0480, 16'h1234, 16'h1234, 4'b1000);
		step_op(16'h04c0, 16'h1234, 16'h1234, 4'b0100);
		step_op(16'h0604, 16'h0000, 16'h0000, 4'b0100);
		step_op(16'h0502, 16'h0005, 16'h0000, 4'b0001);
		step_op(16'h04a0, 16'h1234, 16'h1234, 4'b1001);
		step_op(16'h0404, 16'h7fff, 16'h8000, 4'b0010);
		step_op(16'h0404, 16'hffff, 16'h0000, 4'b0100);
		step_op(16'h0506, 16'h1234, 16'h0001, 4'b0000);
		step_op(16'h0c04, 16'hffff, 16'h0000, 4'b0100);
	endtask : t_alter

	task automatic t_skip;
		step_op(16'h0420, 16'h0001, 16'h0001, 4'b0001);
		step_op(16'h0420, 16'h0001, 16'h0001, 4'b1100);
		step_op(16'h0410, 16'h7fff, 16'h7fff, 4'b0001);
		step_op(16'h0410, 16'h8000, 16'h8000, 4'b0000);
		step_op(16'h0c10, 16'h0001, 16'h0001, 4'b0001);
		step_op(16'h0408, 16'h0002, 16'h0002, 4'b0001);
		step_op(16'h0c08, 16'h0001, 16'h0001, 4'b0000);
		step_op(16'h0402, 16'h0000, 16'h0000, 4'b0001);
		step_op(16'h0c02, 16'h0100, 16'h0100, 4'b0000);
		step_op(16'h0418, 16'h0001, 16'h0001, 4'b0001);
		step_op(16'h0418, 16'h8000, 16'h8000, 4'b0001);
		step_op(16'h0418, 16'h8001, 16'h8001, 4'b0000);
		step_op(16'h0401, 16'h1234, 16'h1234, 4'b0001);
		step_op(16'h0403, 16'h0000, 16'h0000, 4'b0000);
		step_op(16'h0403, 16'h0005, 16'h0005, 4'b0001);
		step_op(16'h0419, 16'h8001, 16'h8001, 4'b0001);
		step_op(16'h0419, 16'h0001, 16'h0001, 4'b0000);
		step_op(16'h0421, 16'h1234, 16'h1234, 4'b1101);
	endtask : t_skip

	task automatic t_refuse;
		step_op(16'h8200, 16'h1234, 16'h1234, 4'b1100);
		step_op(16'hf4ff, 16'h0000, 16'h0000, 4'b0000);
	endtask : t_refuse

	// Port write in the execute cycle is dropped
	task automatic t_clash;
		int lat;
		logic sk;
		wr(`OFS_ACC_A, 16'h1234);
		fork
			wr(`OFS_ACC_A, 16'h0f0f);
			seq_model_i.issue(16'h0000, lat, sk);
		join
		`CHK("write under exec", 16'h1234, acc_a);
		`CHK("exec done", 1'b1, exec_done);
	endtask : t_clash

	initial begin
		rst_b = 1'b0;
		reg_addr = 2'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		n_fail = 0;
		compares = 0;
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		t_reset();
		t_regport();
		t_shift();
		t_alter();
		t_skip();
		t_refuse();
		t_clash();
		test_done();
	end
endmodule : register_ref_microops_test
